/* File: hdl/cap_touch_measure_sequencer.sv */
`timescale 1ns/1ps
module cap_touch_measure_sequencer
    import cap_touch_pkg::*;
#(
    parameter int NUM_DRIVE = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [31:0] rdata,
    input wire logic [((NUM_DRIVE > 9) ? 2 : 1)-1:0] sense_high_pin_in,
    input wire logic comparator_unit_out,
    output logic sense_low_pin_out,
    output logic sense_low_pin_oe,
    output logic [NUM_DRIVE-1:0] drive_electrode_pin_out,
    output logic [NUM_DRIVE-1:0] drive_electrode_pin_oe
);

    //==========================================================================
    // configuration registers
    logic [1:0] scan_mode_select;
    logic method_cmp;
    logic unused_drive_policy;
    logic [3:0] clock_divide_value;
    logic [15:0] drive_select_mask;
    logic [15:0] threshold_count;
    logic touch_is_lower;
    logic [15:0] timeout_count;
    logic [7:0] round_gap;
    logic [7:0] measure_delay;
    logic [7:0] reset_delay;

    // register state and status
    meas_state_t state;
    logic tick;
    logic [3:0] div_cnt;
    logic [19:0] wait_cnt;
    logic [7:0] delay_cnt;
    logic [15:0] iter_cnt;
    logic [3:0] cur_idx;
    logic gap_wait;
    logic shot_done;
    logic touch_flag, notouch_flag, timeout_flag, done_flag;
    logic [15:0] result_count;
    logic [3:0] result_idx;
    logic result_touch, result_timeout;
    logic [3:0] seq_num;

    logic [NUM_DRIVE-1:0] usable_mask;
    logic [NUM_DRIVE-1:0] active_mask;
    logic run_mode, sense, trig, measure_ready, meas_finish, timed_out, touch_hit;
    logic round_done, start_meas;
    logic [15:0] next_count;
    logic [4:0] first_pick, next_pick;
    logic [19:0] gap_target;
    logic [3:0] highest_drive_index;

    assign highest_drive_index = 4'(NUM_DRIVE - 1);

    // lowest enabled electrode at or above a start index; msb is the found flag
    function automatic logic [4:0] next_enabled(input logic [NUM_DRIVE-1:0] mask,
                                                input logic [4:0] from);
        logic [4:0] res;
        res = 5'h00;
        for (int i = NUM_DRIVE - 1; i >= 0; i--) begin
            if (mask[i] && (5'(i) >= from)) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction : next_enabled

    //==========================================================================
    // register writes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            scan_mode_select <= SCAN_INACTIVE;
            method_cmp <= 1'b0;
            unused_drive_policy <= 1'b0;
            clock_divide_value <= DIV_RESET;
            drive_select_mask <= 16'h0000;
            threshold_count <= THRESH_RESET;
            touch_is_lower <= 1'b0;
            timeout_count <= TIMEOUT_RESET;
            round_gap <= DELAY_RESET;
            measure_delay <= DELAY_RESET;
            reset_delay <= DELAY_RESET;
        end else if (we) begin
            case (addr)
                CTRL_OFFSET: begin
                    scan_mode_select <= wdata[CTRL_MODE_LSB +: 2];
                    method_cmp <= wdata[CTRL_METHOD_BIT];
                    unused_drive_policy <= wdata[CTRL_POLICY_BIT];
                    clock_divide_value <= wdata[CTRL_DIV_LSB +: 4];
                    drive_select_mask <= wdata[CTRL_MASK_LSB +: 16];
                end
                THRESH_OFFSET: begin
                    threshold_count <= wdata[15:0];
                    touch_is_lower <= wdata[THRESH_LOWER_BIT];
                end
                TIMEOUT_OFFSET: timeout_count <= wdata[15:0];
                DELAY_OFFSET: begin
                    round_gap <= wdata[DELAY_GAP_LSB +: 8];
                    measure_delay <= wdata[DELAY_MEAS_LSB +: 8];
                    reset_delay <= wdata[DELAY_RST_LSB +: 8];
                end
                default: ;
            endcase
        end
    end

    //==========================================================================
    // function clock divider: ratio is the field value plus one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_cnt <= 4'h0;
            tick <= 1'b0;
        end else if (div_cnt >= clock_divide_value) begin
            div_cnt <= 4'h0;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 4'h1;
            tick <= 1'b0;
        end
    end

    //==========================================================================
    // measurement decode
    always_comb begin
        usable_mask = drive_select_mask[NUM_DRIVE-1:0];
        run_mode = (scan_mode_select == SCAN_SINGLE) || (scan_mode_select == SCAN_CONTINUOUS);
        sense = |sense_high_pin_in;
        trig = method_cmp ? comparator_unit_out : sense;
        next_count = iter_cnt + 16'h0001;
        measure_ready = run_mode && tick && (state == st_measure) && (delay_cnt >= measure_delay);
        timed_out = measure_ready && !trig && (next_count >= timeout_count);
        meas_finish = measure_ready && (trig || timed_out);
        touch_hit = touch_is_lower ? (next_count <= threshold_count) : (next_count > threshold_count);
        first_pick = next_enabled(usable_mask, 5'h00);
        next_pick = next_enabled(usable_mask, {1'b0, cur_idx} + 5'h01);
        round_done = meas_finish && ((scan_mode_select == SCAN_SINGLE) || !next_pick[4]);
        gap_target = {round_gap, GAP_UNIT_SHIFT'(0)};
        start_meas = run_mode && tick && (state == st_reset) && !gap_wait && first_pick[4]
            && !((scan_mode_select == SCAN_SINGLE) && shot_done)
            && (wait_cnt >= {12'h000, reset_delay});
    end

    //==========================================================================
    // sequencer
    // a mode change to inactive aborts at once, not on the divided clock edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= st_reset;
            wait_cnt <= 20'h00000;
            delay_cnt <= 8'h00;
            iter_cnt <= 16'h0000;
            cur_idx <= 4'h0;
            gap_wait <= 1'b0;
            shot_done <= 1'b0;
        end else if (!run_mode) begin
            state <= st_reset;
            wait_cnt <= 20'h00000;
            delay_cnt <= 8'h00;
            iter_cnt <= 16'h0000;
            gap_wait <= 1'b0;
            shot_done <= 1'b0;
        end else if (tick) begin
            if (scan_mode_select != SCAN_SINGLE) begin
                shot_done <= 1'b0;
            end
            case (state)
                st_reset: begin
                    iter_cnt <= 16'h0000;
                    if (gap_wait) begin
                        if (wait_cnt >= gap_target) begin
                            gap_wait <= 1'b0;
                            wait_cnt <= 20'h00000;
                        end else begin
                            wait_cnt <= wait_cnt + 20'h00001;
                        end
                    end else if (start_meas) begin
                        state <= st_charge;
                        wait_cnt <= 20'h00000;
                        if (!usable_mask[cur_idx]) begin
                            cur_idx <= first_pick[3:0];
                        end
                    end else if (!first_pick[4] || shot_done) begin
                        wait_cnt <= 20'h00000;
                    end else begin
                        wait_cnt <= wait_cnt + 20'h00001;
                    end
                end
                st_charge: state <= st_transfer;
                st_transfer: begin
                    state <= st_measure;
                    delay_cnt <= 8'h00;
                end
                st_measure: begin
                    if (delay_cnt < measure_delay) begin
                        delay_cnt <= delay_cnt + 8'h01;
                    end else if (meas_finish) begin
                        state <= st_reset;
                        iter_cnt <= 16'h0000;
                        delay_cnt <= 8'h00;
                        if (scan_mode_select == SCAN_SINGLE) begin
                            shot_done <= 1'b1;
                        end else if (next_pick[4]) begin
                            cur_idx <= next_pick[3:0];
                        end else begin
                            cur_idx <= first_pick[3:0];
                            gap_wait <= 1'b1;
                        end
                    end else begin
                        state <= st_charge;
                        iter_cnt <= next_count;
                        delay_cnt <= 8'h00;
                    end
                end
                default: state <= st_reset;
            endcase
        end
    end

    //==========================================================================
    // results and sticky event flags; an event beats a clear in the same cycle
    logic clr_flags;
    assign clr_flags = we && (addr == STATUS_OFFSET);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result_count <= 16'h0000;
            result_idx <= 4'h0;
            result_touch <= 1'b0;
            result_timeout <= 1'b0;
            seq_num <= 4'h0;
        end else if (meas_finish) begin
            result_count <= timed_out ? iter_cnt : next_count;
            result_idx <= (scan_mode_select == SCAN_SINGLE) ? first_pick[3:0] : cur_idx;
            result_touch <= !timed_out && touch_hit;
            result_timeout <= timed_out;
            if (round_done) begin
                seq_num <= seq_num + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            touch_flag <= 1'b0;
            notouch_flag <= 1'b0;
            timeout_flag <= 1'b0;
            done_flag <= 1'b0;
        end else begin
            touch_flag <= (meas_finish && !timed_out && touch_hit)
                || (touch_flag && !(clr_flags && wdata[ST_TOUCH_BIT]));
            notouch_flag <= (meas_finish && !timed_out && !touch_hit)
                || (notouch_flag && !(clr_flags && wdata[ST_NOTOUCH_BIT]));
            timeout_flag <= timed_out
                || (timeout_flag && !(clr_flags && wdata[ST_TIMEOUT_BIT]));
            done_flag <= round_done || (done_flag && !(clr_flags && wdata[ST_DONE_BIT]));
        end
    end

    //==========================================================================
    // register reads: data stand only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n || !re) begin
            rdata <= 32'h00000000;
        end else begin
            case (addr)
                CTRL_OFFSET: rdata <= {drive_select_mask, 8'h00, clock_divide_value,
                                       unused_drive_policy, method_cmp, scan_mode_select};
                THRESH_OFFSET: rdata <= {15'h0000, touch_is_lower, threshold_count};
                TIMEOUT_OFFSET: rdata <= {16'h0000, timeout_count};
                DELAY_OFFSET: rdata <= {8'h00, reset_delay, measure_delay, round_gap};
                STATUS_OFFSET: rdata <= {12'h000, highest_drive_index, 8'h00, done_flag,
                                         timeout_flag, notouch_flag, touch_flag, 1'b0,
                                         state, (state != st_reset) || gap_wait};
                RESULT_OFFSET: rdata <= {4'h0, seq_num, 2'h0, result_timeout, result_touch,
                                         result_idx, result_count};
                default: rdata <= 32'h00000000;
            endcase
        end
    end

    //==========================================================================
    // pads: sense-high is never driven; sense-low drains in reset and transfer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sense_low_pin_out <= 1'b0;
            sense_low_pin_oe <= 1'b0;
        end else begin
            sense_low_pin_out <= 1'b0;
            sense_low_pin_oe <= (state == st_reset) || (state == st_transfer);
        end
    end

    // single-shot fires all enabled electrodes together; continuous walks one at a time
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DRIVE; gi++) begin : g_drive
            assign active_mask[gi] = usable_mask[gi]
                && ((scan_mode_select == SCAN_SINGLE) || (cur_idx == 4'(gi)));

            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    drive_electrode_pin_out[gi] <= 1'b0;
                    drive_electrode_pin_oe[gi] <= 1'b0;
                end else if (active_mask[gi]) begin
                    drive_electrode_pin_out[gi] <= (state == st_charge) || (state == st_transfer);
                    drive_electrode_pin_oe[gi] <= (state != st_measure);
                end else begin
                    drive_electrode_pin_out[gi] <= 1'b0;
                    drive_electrode_pin_oe[gi] <= unused_drive_policy;
                end
            end

            unused_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
                !active_mask[gi] |=> !drive_electrode_pin_out[gi]
                    && (drive_electrode_pin_oe[gi] == $past(unused_drive_policy)))
                else $error("unused drive electrode not parked per policy");
        end
    endgenerate

    //==========================================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence walk_charge_s;
        (state == st_charge) && tick && run_mode ##1 (state == st_transfer);
    endsequence

    sequence walk_transfer_s;
        !tick [*1] ##0 (state == st_transfer);
    endsequence

    idle_in_reset_a: assert property (!run_mode |=> state == st_reset)
        else $error("sequencer not in reset state while inactive");

    step_order_a: assert property (
        (state == st_charge) && tick && run_mode |=> (state == st_transfer))
        else $error("charge did not advance to transfer");

    charge_walk_a: assert property (
        walk_charge_s ##0 (clock_divide_value != 4'h0) |-> walk_transfer_s)
        else $error("transfer left early on a slow divided clock");

    finish_return_a: assert property (meas_finish |=> state == st_reset)
        else $error("finished measurement did not return to reset");

    divider_ratio_a: assert property (
        tick && (clock_divide_value == 4'h1) && !we |=> !tick ##1 tick)
        else $error("divide by two tick spacing wrong");

    hold_between_ticks_a: assert property (!tick && run_mode |=> $stable(state))
        else $error("state moved without a divided clock tick");

    classify_a: assert property (
        meas_finish && !timed_out && !we |=> result_touch == (touch_is_lower ?
            (result_count <= threshold_count) : (result_count > threshold_count)))
        else $error("touch classification wrong");

    timeout_flag_a: assert property (timed_out |=> timeout_flag && result_timeout
        && !result_touch)
        else $error("timeout not reported");

    gap_hold_a: assert property (
        gap_wait && run_mode && (wait_cnt < gap_target) |=> state == st_reset)
        else $error("round gap cut short");

    measure_delay_a: assert property (measure_ready |-> delay_cnt >= measure_delay)
        else $error("sampled before measure delay elapsed");

    reset_delay_a: assert property (start_meas |-> wait_cnt >= {12'h000, reset_delay})
        else $error("left reset before reset delay");

    iter_clear_a: assert property (state == st_reset |-> iter_cnt == 16'h0000)
        else $error("iteration counter not clear in reset");

endmodule : cap_touch_measure_sequencer

/* File: hdl/cap_touch_pkg.sv */
//==============================================================================
// Overview of operation
// - each measured electrode walks states 0 reset, 1 charge, 2 transfer, 3 measure.
// - unselected drive electrodes stay high-impedance or driven low, per unused policy.
// - with no measurement running the sequencer sits in state 0.
// - a measurement loops states 1-3 until trigger or timeout count.
// - after a measurement ends, state 0 is entered before any new one.
// - divided clock uses any integer ratio 1 to 16 from the divider field.
// - all delays and iteration counts run on the divided clock.
// - a triggered count is classified touch or no-touch against the threshold.
// - touch is count above threshold, swapped when touch-is-lower is set.
// - reaching the timeout count ends the electrode and flags a timeout.
// - after a round, wait 4096 times the round gap before the next round.
// - on entering state 3, wait the measure delay before sampling.
// - stay in state 0 for the reset delay before the next electrode.
// - the method bit picks sense pad or comparator as trigger source.
// - pad mode samples the sense-high pad as input; one is the trigger.
// - comparator mode samples the comparator output; one is the trigger.
// - up to sixteen drive electrodes; above nine a second sense-high pin exists.
// - scan mode 0 inactive, 1 single-shot all enabled, 2 continuous walking.
package cap_touch_pkg;

    //==========================================================================
    // register map
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] THRESH_OFFSET = 8'h04;
    localparam logic [7:0] TIMEOUT_OFFSET = 8'h08;
    localparam logic [7:0] DELAY_OFFSET = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam logic [7:0] RESULT_OFFSET = 8'h14;

    //==========================================================================
    // field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_METHOD_BIT = 2;
    localparam int CTRL_POLICY_BIT = 3;
    localparam int CTRL_DIV_LSB = 4;
    localparam int CTRL_MASK_LSB = 16;
    localparam int THRESH_LOWER_BIT = 16;
    localparam int DELAY_GAP_LSB = 0;
    localparam int DELAY_MEAS_LSB = 8;
    localparam int DELAY_RST_LSB = 16;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_STATE_LSB = 1;
    localparam int ST_TOUCH_BIT = 4;
    localparam int ST_NOTOUCH_BIT = 5;
    localparam int ST_TIMEOUT_BIT = 6;
    localparam int ST_DONE_BIT = 7;
    localparam int ST_HIGHEST_DRIVE_INDEX_LSB = 16;
    localparam int RES_IDX_LSB = 16;
    localparam int RES_TOUCH_BIT = 20;
    localparam int RES_TO_BIT = 21;
    localparam int RES_SEQ_LSB = 24;

    //==========================================================================
    // values after reset and counts
    localparam logic [15:0] THRESH_RESET = 16'h0000;
    localparam logic [15:0] TIMEOUT_RESET = 16'hFFFF;
    localparam logic [7:0] DELAY_RESET = 8'h00;
    localparam logic [3:0] DIV_RESET = 4'h0;
    localparam int GAP_UNIT_SHIFT = 12;

    //==========================================================================
    // scan modes and measurement states
    localparam logic [1:0] SCAN_INACTIVE = 2'h0;
    localparam logic [1:0] SCAN_SINGLE = 2'h1;
    localparam logic [1:0] SCAN_CONTINUOUS = 2'h2;

    typedef enum logic [1:0] {st_reset, st_charge, st_transfer, st_measure} meas_state_t;

endpackage : cap_touch_pkg

/* File: sim/cap_touch_electrode_model.sv */
`timescale 1ns/1ps
//==============================================================================
// electrodes, measurement capacitor and comparator
module cap_touch_electrode_model (
    input wire logic mclk,
    input wire logic [15:0] drive_out,
    input wire logic [15:0] drive_oe,
    input wire logic sense_low_oe,
    input wire logic [7:0] trip_pad,
    input wire logic [7:0] trip_cmp,
    output logic [1:0] sense_high,
    output logic comparator
);
    logic [7:0] pulses = 8'h00;
    logic prev_charging = 1'b0;
    // charge builds on each rise of an actively driven-high electrode and clears while sense-low drains with none driven
    wire logic charging = |(drive_out & drive_oe);
    always @(posedge mclk) begin
        prev_charging <= charging;
        if (sense_low_oe && !charging) begin
            pulses <= 8'h00;
        end else if (charging && !prev_charging && pulses != 8'hFF) begin
            pulses <= pulses + 8'h01;
        end
    end
    // second pad held low: a trip only shows through the OR of both pads
    assign sense_high = {1'b0, pulses >= trip_pad};
    assign comparator = pulses >= trip_cmp;
endmodule : cap_touch_electrode_model

/* File: sim/cap_touch_measure_sequencer_test.sv */
`timescale 1ns/1ps
module cap_touch_measure_sequencer_test;
    import cap_touch_pkg::*;
    logic mclk, rst_n, we, re, cmp_out, low_out, low_oe;
    logic [7:0] addr, trip_pad, trip_cmp;
    logic [31:0] wdata, rdata, rd_val;
    logic [1:0] high_in;
    logic [15:0] drive_out, drive_oe;
    int errors = 0, checked = 0, hi_cnt = 0, lo_cnt = 0;

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    cap_touch_measure_sequencer #(.NUM_DRIVE(16)) i_dut (.mclk(mclk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
        .sense_high_pin_in(high_in), .comparator_unit_out(cmp_out),
        .sense_low_pin_out(low_out), .sense_low_pin_oe(low_oe),
        .drive_electrode_pin_out(drive_out), .drive_electrode_pin_oe(drive_oe));
    cap_touch_electrode_model i_model (.mclk(mclk), .drive_out(drive_out),
        .drive_oe(drive_oe), .sense_low_oe(low_oe), .trip_pad(trip_pad),
        .trip_cmp(trip_cmp), .sense_high(high_in), .comparator(cmp_out));

    always @(posedge mclk) if (drive_out[0]) hi_cnt <= hi_cnt + 1;
    // electrode 0 floating with the drain off only happens in the measure state
    always @(posedge mclk) if (!low_oe && !drive_oe[0]) lo_cnt <= lo_cnt + 1;

    //==========================================================================
    // bus and checking helpers
    task stop_test;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge mclk);
        we <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        re <= 1'b1;
        @(posedge mclk);
        re <= 1'b0;
        #1 rd_val = rdata;
    endtask : rd
    task wait_done;
        int n;
        n = 0;
        rd(STATUS_OFFSET);
        while (rd_val[ST_DONE_BIT] !== 1'b1 && n < 300) begin
            rd(STATUS_OFFSET);
            n++;
        end
        check("done", 32'h1, 32'(rd_val[ST_DONE_BIT]));
    endtask : wait_done
    // mode 0 first so a single shot can be launched again
    task run(input logic [31:0] ctrl);
        wr(CTRL_OFFSET, 32'h0000_0000);
        wr(STATUS_OFFSET, 32'h0000_00F0);
        hi_cnt = 0;
        wr(CTRL_OFFSET, ctrl);
        wait_done();
    endtask : run

    //==========================================================================
    // scenarios
    task t_regs;
        rd(STATUS_OFFSET);
        check("drain idle", 32'h1, 32'(low_oe));
        check("drain level", 32'h0, 32'(low_out));
        check("highest index", 32'hF, 32'(rd_val[19:16]));
        check("idle state", 32'h0, 32'(rd_val[2:0]));
        rd(TIMEOUT_OFFSET);
        check("timeout reset", 32'h0000_FFFF, rd_val);
        rd(8'h40);
        check("unmapped", 32'h0, rd_val);
    endtask : t_regs
    task t_classify;
        logic t;
        for (int i = 0; i < 4; i++) begin
            t = (i % 2 == 0);
            wr(THRESH_OFFSET, {15'h0000, i >= 2, (i == 0 || i == 3) ? 16'h0004 : 16'h0005});
            run(32'h0001_0001);
            rd(RESULT_OFFSET);
            check("count", 32'h5, 32'(rd_val[15:0]));
            check("touch", 32'(t), 32'(rd_val[RES_TOUCH_BIT]));
            rd(STATUS_OFFSET);
            check("flags", 32'({!t, t}), 32'(rd_val[5:4]));
            check("end state", 32'h0, 32'(rd_val[2:1]));
        end
    endtask : t_classify
    task t_method;
        trip_cmp = 8'h03;
        run(32'h0001_0005);
        rd(RESULT_OFFSET);
        check("comparator count", 32'h3, 32'(rd_val[15:0]));
        trip_pad = 8'hC8;
        trip_cmp = 8'hC8;
        wr(TIMEOUT_OFFSET, 32'h0000_0004);
        run(32'h0001_0001);
        rd(RESULT_OFFSET);
        check("timeout count", 32'h3, 32'(rd_val[15:0]));
        check("timeout bit", 32'h1, 32'(rd_val[RES_TO_BIT]));
        rd(STATUS_OFFSET);
        check("timeout flags", 32'h4, 32'(rd_val[6:4]));
        wr(TIMEOUT_OFFSET, 32'h0000_00FF);
    endtask : t_method
    // one charge-transfer pass keeps an electrode high for two ticks
    // ratios from four up keep the divided clock at or below 4 MHz
    task t_divider;
        trip_pad = 8'h01;
        for (int d = 0; d < 16; d = 2 * d + 1) begin
            run(32'h0001_0001 | (d << CTRL_DIV_LSB));
            check("high time", 32'(2 * (d + 1)), 32'(hi_cnt));
        end
    endtask : t_divider
    // reset delay 3 and measure delay 4 on an undivided clock, trigger on first sample
    task t_delays;
        wr(CTRL_OFFSET, 32'h0000_0000);
        wr(DELAY_OFFSET, 32'h0003_0400);
        wr(STATUS_OFFSET, 32'h0000_00F0);
        lo_cnt = 0;
        wr(CTRL_OFFSET, 32'h0001_0001);
        repeat (4) @(posedge mclk);
        #1 check("reset delay hold", 32'h0, 32'(drive_out[0]));
        @(posedge mclk);
        #1 check("reset delay end", 32'h1, 32'(drive_out[0]));
        wait_done();
        check("measure time", 32'h5, 32'(lo_cnt));
    endtask : t_delays
    task t_policy;
        wr(CTRL_OFFSET, 32'h0001_0008);
        repeat (3) @(posedge mclk);
        check("unused low", 32'h7FFF, 32'(drive_oe[15:1]));
        check("unused out", 32'h0, 32'(drive_out[15:1]));
        wr(CTRL_OFFSET, 32'h0001_0000);
        repeat (3) @(posedge mclk);
        check("unused hiz", 32'h0, 32'(drive_oe[15:1]));
    endtask : t_policy
    task t_continuous;
        logic [3:0] seq;
        trip_pad = 8'h02;
        run(32'h0005_0002);
        rd(RESULT_OFFSET);
        check("last index", 32'h2, 32'(rd_val[19:16]));
        seq = rd_val[27:24];
        wr(STATUS_OFFSET, 32'h0000_00F0);
        wait_done();
        rd(RESULT_OFFSET);
        check("sequence", 32'(4'(seq + 4'h1)), 32'(rd_val[27:24]));
        wr(CTRL_OFFSET, 32'h0000_0000);
        rd(STATUS_OFFSET);
        check("stopped", 32'h0, 32'(rd_val[2:0]));
    endtask : t_continuous

    initial begin
        rst_n = 1'b0;
        we = 1'b0;
        re = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        trip_pad = 8'h05;
        trip_cmp = 8'hC8;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_classify();
        t_method();
        t_divider();
        t_delays();
        t_policy();
        t_continuous();
        stop_test();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        errors++;
        $display("Error watchdog expected done seen hang");
        stop_test();
    end
endmodule : cap_touch_measure_sequencer_test
